// *** ieci_core.sv ***
// How it works
// - Command 23 loads low byte as per-input rising edge detect enables.
// - Command 24 loads low byte as per-input falling edge detect enables.
// - An enabled detected edge raises the interrupt request.
// - Every accepted command returns the synchronised input levels in the top byte.
// - Every accepted command echoes its code in the echo byte.
// - Command 28 enables or disables each input's up counter.
// - For commands 23-2C, low parameter bit n addresses input n.
// - Command 29 reloads masked counters with their reset value, others keep count.
// - Command 2A sets overflow interrupt enables; only enabled overflows interrupt.
// - Command 2B sets per-input value match interrupt enables.
// - Command 2C picks count edge: one means falling, zero means rising.
// - Command 2F selects the counter from the low three parameter bits.
// - Counter read reply holds high byte in byte one, low in byte zero.
// - Enabled counter reaching its match value (set by 48-4F) interrupts.
// - Commands 40-47 store each counter's reset value, its starting value.
// - Command 60 reports change flag in bit 1, counter flag in bit 2.
//
// The register addresses and strobed register access were chosen for this implementation.
`include "ieci_defs.svh"

module ieci_core (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [7:0] ISOLATED_INPUT,
   output logic IRQ
);
   import ieci_pkg::*;

   localparam int NCH = 8;

   function automatic logic code_known(input logic [7:0] c);
      case (c)
         `IECI_C_RISE_EN, `IECI_C_FALL_EN, `IECI_C_CNT_EN, `IECI_C_CNT_RELOAD,
         `IECI_C_OVF_EN, `IECI_C_MATCH_EN, `IECI_C_CNT_EDGE, `IECI_C_CNT_READ,
         `IECI_C_FLAGS_READ: code_known = 1'b1;
         default: code_known = (c[7:4] == 4'(`IECI_C_RSTVAL_BASE >> 4));
      endcase
   endfunction : code_known

   // One-hot channel decode of a 40-4F code within its group of eight
   function automatic logic [7:0] chan_sel(input logic [7:0] c, input logic [7:0] base);
      chan_sel = (c[7:3] == base[7:3]) ? (8'h01 << c[2:0]) : 8'h00;
   endfunction : chan_sel

   logic [7:0] in_meta;
   logic [7:0] in_sync;
   logic [7:0] in_prev;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] cnt_en;
   logic [7:0] ovf_en;
   logic [7:0] match_en;
   logic [7:0] edge_fall;
   logic cos_flag;
   logic cnt_flag;
   logic next_cos_flag;
   logic next_cnt_flag;
   logic cos_evt;
   logic cnt_evt;
   logic [7:0] ovf_v;
   logic [7:0] match_v;
   ieci_cmd_s cmd;
   ieci_reply_s reply;
   logic accept;
   logic flag_clr;
   logic [7:0] rst_sel;
   logic [7:0] match_sel;
   logic [15:0] sel_count;
   ieci_chan_ctl_s ctl [NCH];
   ieci_chan_st_s st [NCH];

   assign cmd = ieci_cmd_s'(WDATA);
   assign accept = WR && ADDR == `IECI_OFS_CMD && cmd.top == 8'h00 && code_known(cmd.code);
   assign flag_clr = accept && cmd.code == `IECI_C_FLAGS_READ;

   // Decoded once here because a function result cannot be indexed per channel
   assign rst_sel = accept ? chan_sel(cmd.code, `IECI_C_RSTVAL_BASE) : 8'h00;
   assign match_sel = accept ? chan_sel(cmd.code, `IECI_C_MATCHVAL_BASE) : 8'h00;

   // Only in_sync and in_prev are read by logic; in_meta may be metastable
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         in_meta <= `IECI_RST_MASK;
         in_sync <= `IECI_RST_MASK;
         in_prev <= `IECI_RST_MASK;
      end else begin
         in_meta <= ISOLATED_INPUT;
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   assign rise = in_sync & ~in_prev;
   assign fall = ~in_sync & in_prev;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rise_en <= `IECI_RST_MASK;
         fall_en <= `IECI_RST_MASK;
         cnt_en <= `IECI_RST_MASK;
         ovf_en <= `IECI_RST_MASK;
         match_en <= `IECI_RST_MASK;
         edge_fall <= `IECI_RST_MASK;
      end else if (accept) begin
         case (cmd.code)
            `IECI_C_RISE_EN: rise_en <= cmd.low;
            `IECI_C_FALL_EN: fall_en <= cmd.low;
            `IECI_C_CNT_EN: cnt_en <= cmd.low;
            `IECI_C_OVF_EN: ovf_en <= cmd.low;
            `IECI_C_MATCH_EN: match_en <= cmd.low;
            `IECI_C_CNT_EDGE: edge_fall <= cmd.low;
            default: begin
            end
         endcase
      end
   end

   generate
      for (genvar i = 0; i < NCH; i++) begin : g_chan
         assign ctl[i].cnt_en = cnt_en[i];
         assign ctl[i].edge_fall = edge_fall[i];
         assign ctl[i].reload = accept && cmd.code == `IECI_C_CNT_RELOAD && cmd.low[i];
         assign ctl[i].ld_rst = rst_sel[i];
         assign ctl[i].ld_match = match_sel[i];
         assign ctl[i].value = {cmd.high, cmd.low};
         assign ovf_v[i] = st[i].ovf;
         assign match_v[i] = st[i].match;
         ieci_chan u_chan (
            .clk(CLK_SYS),
            .rst_n(RST_N),
            .rise(rise[i]),
            .fall(fall[i]),
            .ctl(ctl[i]),
            .st(st[i])
         );
      end
   endgenerate

   assign cos_evt = |((rise & rise_en) | (fall & fall_en));
   assign cnt_evt = |((ovf_v & ovf_en) | (match_v & match_en));

   // A new event in the clearing cycle survives: set wins over clear
   assign next_cos_flag = (cos_flag && !flag_clr) || cos_evt;
   assign next_cnt_flag = (cnt_flag && !flag_clr) || cnt_evt;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         cos_flag <= 1'b0;
         cnt_flag <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         cos_flag <= next_cos_flag;
         cnt_flag <= next_cnt_flag;
         IRQ <= next_cos_flag || next_cnt_flag;
      end
   end

   assign sel_count = st[cmd.low[2:0]].count;

   // Refused commands leave the previous reply in place
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         reply <= `IECI_RST_WORD;
      end else if (accept) begin
         reply.snapshot <= in_sync;
         reply.echo <= cmd.code;
         case (cmd.code)
            `IECI_C_CNT_READ: begin
               reply.high <= sel_count[15:8];
               reply.low <= sel_count[7:0];
            end
            `IECI_C_FLAGS_READ: begin
               reply.high <= 8'h00;
               reply.low <= 8'h00;
               reply.low[`IECI_FLAG_COS] <= cos_flag;
               reply.low[`IECI_FLAG_CNT] <= cnt_flag;
            end
            default: begin
               reply.high <= 8'h00;
               reply.low <= 8'h00;
            end
         endcase
      end
   end

   // Read data stands for exactly one cycle after the strobe
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= `IECI_RST_WORD;
      end else if (RD) begin
         case (ADDR)
            `IECI_OFS_REPLY: RDATA <= reply;
            `IECI_OFS_STATUS: RDATA <= {16'h0000, 5'h00, cnt_flag, cos_flag, 1'b0, in_sync};
            default: RDATA <= `IECI_RST_WORD;
         endcase
      end else begin
         RDATA <= `IECI_RST_WORD;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   AST_RISE_CFG: assert property (accept && cmd.code == `IECI_C_RISE_EN
      |=> rise_en == $past(WDATA[7:0]))
      else $error("Rising enables not loaded");
   AST_FALL_CFG: assert property (accept && cmd.code == `IECI_C_FALL_EN
      |=> fall_en == $past(WDATA[7:0]))
      else $error("Falling enables not loaded");
   AST_COS_IRQ: assert property (cos_evt |=> cos_flag && IRQ)
      else $error("Edge event did not raise request");
   AST_SNAPSHOT: assert property (accept |=> reply.snapshot == $past(in_sync))
      else $error("Input snapshot wrong");
   AST_ECHO: assert property (accept |=> reply.echo == $past(WDATA[23:16]))
      else $error("Code echo wrong");
   AST_CNT_EN: assert property (accept && cmd.code == `IECI_C_CNT_EN
      |=> cnt_en == $past(WDATA[7:0]))
      else $error("Counter enables not loaded");
   AST_EDGE_SEL: assert property (accept && cmd.code == `IECI_C_CNT_EDGE
      |=> edge_fall == $past(WDATA[7:0]))
      else $error("Count edge select not loaded");
   AST_OVF_IRQ: assert property (|(ovf_v & ovf_en) |=> cnt_flag && IRQ)
      else $error("Enabled overflow did not raise flag");
   AST_MATCH_IRQ: assert property (|(match_v & match_en) |=> cnt_flag && IRQ)
      else $error("Enabled match did not raise request");
   AST_READ: assert property (accept && cmd.code == `IECI_C_CNT_READ
      |=> {reply.high, reply.low} == $past(sel_count))
      else $error("Counter read value wrong");
   AST_FLAGS: assert property (flag_clr && !cos_evt && !cnt_evt
      |=> reply.low[`IECI_FLAG_COS] == $past(cos_flag) && !cos_flag && !cnt_flag
      && reply.low[`IECI_FLAG_CNT] == $past(cnt_flag))
      else $error("Flag report or clear wrong");
   AST_RDATA_ONE: assert property (RD ##1 !RD |=> RDATA == `IECI_RST_WORD)
      else $error("Read data stood too long");
   AST_OVF_CFG: assert property (accept && cmd.code == `IECI_C_OVF_EN
      |=> ovf_en == $past(WDATA[7:0]))
      else $error("Overflow enables not loaded");
   AST_MATCH_CFG: assert property (accept && cmd.code == `IECI_C_MATCH_EN
      |=> match_en == $past(WDATA[7:0]))
      else $error("Match enables not loaded");
   AST_RISE_KEEP: assert property (!(accept && cmd.code == `IECI_C_RISE_EN)
      |=> $stable(rise_en))
      else $error("Rising enables changed without their command");
   AST_CNT_KEEP: assert property (!(accept && cmd.code == `IECI_C_CNT_EN)
      |=> $stable(cnt_en))
      else $error("Counter enables changed without their command");
   // A refused command must not disturb what software may still read back
   AST_REFUSED: assert property (!accept |=> $stable(reply))
      else $error("Reply changed without an accepted command");
   AST_NO_IRQ: assert property (flag_clr && !cos_evt && !cnt_evt |=> !IRQ)
      else $error("Request stayed up after a clean clear");
   AST_LD_SEL: assert property ((rst_sel | match_sel) != 8'h00
      |-> accept && $onehot(rst_sel | match_sel)
      && (rst_sel[cmd.code[2:0]] || match_sel[cmd.code[2:0]]))
      else $error("Value load decode wrong");
   AST_SEL_CH: assert property (accept && cmd.code == `IECI_C_CNT_READ && cmd.low == 8'h05
      |=> {reply.high, reply.low} == $past(st[5].count))
      else $error("Counter selector picked the wrong channel");
   AST_REPLY_RD: assert property (RD && ADDR == `IECI_OFS_REPLY
      |=> RDATA == $past(reply))
      else $error("Reply read wrong");
   AST_STATUS_RD: assert property (RD && ADDR == `IECI_OFS_STATUS
      |=> RDATA[7:0] == $past(in_sync) && RDATA[10:9] == $past({cnt_flag, cos_flag}))
      else $error("Status read wrong");
   // Idle read data is zero so a stray sample never shows stale state
   AST_RDATA_IDLE: assert property (!RD |=> RDATA == `IECI_RST_WORD)
      else $error("Read data without a read strobe");

   COV_COS: cover property (cos_evt ##[1:20] flag_clr);
   COV_READ: cover property (accept && cmd.code == `IECI_C_CNT_READ ##1 RD);
   COV_RELOAD: cover property (accept && cmd.code == `IECI_C_CNT_RELOAD);
   COV_SET_CLR: cover property (flag_clr && cnt_evt);
endmodule : ieci_core

// *** ieci_defs.svh ***
`ifndef IECI_DEFS_SVH
`define IECI_DEFS_SVH

// Register offsets on the plain register port
`define IECI_OFS_CMD 8'h00
`define IECI_OFS_REPLY 8'h04
`define IECI_OFS_STATUS 8'h08

// Command word field positions
`define IECI_POS_LOW 0
`define IECI_POS_HIGH 8
`define IECI_POS_CODE 16
`define IECI_POS_TOP 24

// Command codes
`define IECI_C_RISE_EN 8'h23
`define IECI_C_FALL_EN 8'h24
`define IECI_C_CNT_EN 8'h28
`define IECI_C_CNT_RELOAD 8'h29
`define IECI_C_OVF_EN 8'h2a
`define IECI_C_MATCH_EN 8'h2b
`define IECI_C_CNT_EDGE 8'h2c
`define IECI_C_CNT_READ 8'h2f
`define IECI_C_RSTVAL_BASE 8'h40
`define IECI_C_MATCHVAL_BASE 8'h48
`define IECI_C_FLAGS_READ 8'h60

// Flag bit positions in the flags reply
`define IECI_FLAG_COS 1
`define IECI_FLAG_CNT 2

// Reset values and the counter top value
`define IECI_RST_MASK 8'h00
`define IECI_RST_CNT 16'h0000
`define IECI_RST_WORD 32'h0000_0000
`define IECI_CNT_MAX 16'hffff

`endif

// *** ieci_pkg.sv ***
package ieci_pkg;
   typedef struct packed {
      logic [7:0] top;
      logic [7:0] code;
      logic [7:0] high;
      logic [7:0] low;
   } ieci_cmd_s;

   typedef struct packed {
      logic [7:0] snapshot;
      logic [7:0] echo;
      logic [7:0] high;
      logic [7:0] low;
   } ieci_reply_s;

   typedef struct packed {
      logic cnt_en;
      logic edge_fall;
      logic reload;
      logic ld_rst;
      logic ld_match;
      logic [15:0] value;
   } ieci_chan_ctl_s;

   typedef struct packed {
      logic [15:0] count;
      logic ovf;
      logic match;
   } ieci_chan_st_s;
endpackage : ieci_pkg

// *** ieci_chan.sv ***
`include "ieci_defs.svh"

module ieci_chan (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rise,
   input wire logic fall,
   input ieci_pkg::ieci_chan_ctl_s ctl,
   output ieci_pkg::ieci_chan_st_s st
);
   import ieci_pkg::*;

   logic [15:0] rst_val;
   logic [15:0] match_val;
   logic hit;

   assign hit = ctl.cnt_en && (ctl.edge_fall ? fall : rise);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_val <= `IECI_RST_CNT;
         match_val <= `IECI_RST_CNT;
      end else begin
         if (ctl.ld_rst) begin
            rst_val <= ctl.value;
         end
         if (ctl.ld_match) begin
            match_val <= ctl.value;
         end
      end
   end

   // Reload beats a same-cycle edge so software sees a clean start value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st.ovf <= 1'b0;
         st.match <= 1'b0;
         if (ctl.reload) begin
            st.count <= rst_val;
         end else if (hit) begin
            if (st.count == `IECI_CNT_MAX) begin
               st.count <= rst_val;
               st.ovf <= 1'b1;
               st.match <= (rst_val == match_val);
            end else begin
               st.count <= st.count + 16'h0001;
               st.match <= ((st.count + 16'h0001) == match_val);
            end
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_HOLD: assert property (!ctl.cnt_en && !ctl.reload |=> $stable(st.count))
      else $error("Disabled counter changed");
   AST_WRAP: assert property (hit && !ctl.reload && st.count == `IECI_CNT_MAX
      |=> st.ovf && st.count == $past(rst_val))
      else $error("Overflow not flagged");
   AST_COUNT: assert property (hit && !ctl.reload && st.count != `IECI_CNT_MAX
      |=> st.count == $past(st.count) + 16'h0001 && !st.ovf)
      else $error("Counter did not step by one");
   AST_RELOAD: assert property (ctl.reload |=> st.count == $past(rst_val))
      else $error("Reload did not restore the reset value");
   AST_LD_RST: assert property (ctl.ld_rst |=> rst_val == $past(ctl.value))
      else $error("Reset value not stored");
   AST_LD_MATCH: assert property (ctl.ld_match |=> match_val == $past(ctl.value))
      else $error("Match value not stored");
   COV_OVF: cover property (st.ovf);
endmodule : ieci_chan

// *** ieci_core_test.sv ***
module ieci_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   import ieci_pkg::*;

   logic CLK_SYS, RST_N, WR, RD, IRQ;
   logic [7:0] ADDR, ISOLATED_INPUT;
   logic [31:0] WDATA, RDATA;
   int errors, comparisons;
   logic [31:0] seed;
   int cnt[8], rstv[8], mv[8];
   logic [7:0] ren, fen, cen, oen, men, edg, inp;
   logic fc, fk;
   ieci_reply_s exp_r;
   logic [7:0] codes[11] = '{8'h23, 8'h24, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2f,
                             8'h40, 8'h48, 8'h60};

   ieci_core dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
                    .WR(WR), .RD(RD), .RDATA(RDATA), .ISOLATED_INPUT(ISOLATED_INPUT),
                    .IRQ(IRQ));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task tally_and_finish();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK_SYS);
      WR <= 1'b0;
   endtask : bus_wr

   // Sample just after the edge so the registered read data has landed
   task bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK_SYS);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : bus_rd

   task model_reset();
      {ren, fen, cen, oen, men, edg} = '0;
      fc = 1'b0;
      fk = 1'b0;
      exp_r = '0;
      for (int n = 0; n < 8; n++) begin
         cnt[n] = 0;
         rstv[n] = 0;
         mv[n] = 0;
      end
   endtask : model_reset

   task cmd(input logic [7:0] top, input logic [7:0] code, input logic [7:0] hi,
            input logic [7:0] lo);
      logic [31:0] d;
      bus_wr(8'h00, {top, code, hi, lo});
      if (top == 8'h00 && (code inside {8'h23, 8'h24, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c,
          8'h2f, 8'h60} || code[7:4] == 4'h4)) begin
         exp_r = {inp, code, 16'h0000};
         case (code)
            8'h23: ren = lo;
            8'h24: fen = lo;
            8'h28: cen = lo;
            8'h29: for (int n = 0; n < 8; n++) if (lo[n]) cnt[n] = rstv[n];
            8'h2a: oen = lo;
            8'h2b: men = lo;
            8'h2c: edg = lo;
            8'h2f: exp_r[15:0] = 16'(cnt[lo[2:0]]);
            8'h60: begin
               exp_r.low = {5'h00, fk, fc, 1'b0};
               fc = 1'b0;
               fk = 1'b0;
            end
            default: if (code[3]) mv[code[2:0]] = {hi, lo}; else rstv[code[2:0]] = {hi, lo};
         endcase
      end
      bus_rd(8'h04, d);
      chk(d, exp_r);
      chk(32'(IRQ), 32'(fc | fk));
   endtask : cmd

   // Inputs settle six cycles so the synchroniser and edge stage have passed them
   task set_in(input logic [7:0] v);
      logic r, f;
      @(posedge CLK_SYS);
      ISOLATED_INPUT <= v;
      for (int n = 0; n < 8; n++) begin
         r = !inp[n] && v[n];
         f = inp[n] && !v[n];
         if ((r && ren[n]) || (f && fen[n])) fc = 1'b1;
         if (cen[n] && (edg[n] ? f : r)) begin
            if (cnt[n] == 16'hffff) begin
               cnt[n] = rstv[n];
               if (oen[n]) fk = 1'b1;
            end else cnt[n]++;
            if (cnt[n] == mv[n] && men[n]) fk = 1'b1;
         end
      end
      inp = v;
      repeat (6) @(posedge CLK_SYS);
      #1 chk(32'(IRQ), 32'(fc | fk));
   endtask : set_in

   initial begin
      CLK_SYS = 1'b0;
      forever #25 CLK_SYS = ~CLK_SYS;
   end

   initial begin
      #2000000;
      errors++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] d;
      logic [7:0] c, lo;
      {WR, RD, ADDR, WDATA, ISOLATED_INPUT, inp} = '0;
      RST_N = 1'b0;
      seed = 32'h44fe;
      model_reset();
      repeat (4) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      bus_rd(8'h04, d);
      chk(d, 32'h0);
      bus_rd(8'h0c, d);
      chk(d, 32'h0);
      // Random traffic covers every code with random masks and input changes
      for (int i = 0; i < 300; i++) begin
         set_in(8'(rnd()));
         c = codes[rnd() % 11];
         if (c[7:4] == 4'h4) c = c + 8'(rnd() & 7);
         lo = 8'(rnd());
         if (c == 8'h2f) lo = lo & 8'h07;
         cmd(8'h00, c, 8'(rnd()), lo);
         if (i % 8 == 0) begin
            cmd(8'h01, c, 8'h00, 8'hff);
            cmd(8'h00, 8'h25, 8'h00, 8'hff);
            bus_wr(8'h10, 32'h0029_00ff);
            bus_rd(8'h08, d);
            chk(d, {21'h0, fk, fc, 1'b0, inp});
            #1 @(posedge CLK_SYS);
            #1 chk(RDATA, 32'h0);
         end
      end
      // Wrap past the top of the count, with and without its interrupt enable
      set_in(8'h00);
      cmd(8'h00, 8'h23, 8'h00, 8'h00);
      cmd(8'h00, 8'h24, 8'h00, 8'h00);
      cmd(8'h00, 8'h2b, 8'h00, 8'h00);
      cmd(8'h00, 8'h2c, 8'h00, 8'h00);
      cmd(8'h00, 8'h28, 8'h00, 8'h01);
      for (int k = 0; k < 2; k++) begin
         cmd(8'h00, 8'h40, 8'hff, 8'hff);
         cmd(8'h00, 8'h2a, 8'h00, 8'(1 - k));
         cmd(8'h00, 8'h29, 8'h00, 8'h01);
         cmd(8'h00, 8'h60, 8'h00, 8'h00);
         set_in(8'h01);
         cmd(8'h00, 8'h2f, 8'h00, 8'h00);
         cmd(8'h00, 8'h60, 8'h00, 8'h00);
         set_in(8'h00);
      end
      // Count on falling edges up to a match value
      cmd(8'h00, 8'h40, 8'h00, 8'h00);
      cmd(8'h00, 8'h48, 8'h00, 8'h02);
      cmd(8'h00, 8'h2b, 8'h00, 8'h01);
      cmd(8'h00, 8'h2c, 8'h00, 8'h01);
      cmd(8'h00, 8'h29, 8'h00, 8'h01);
      for (int k = 0; k < 4; k++) set_in(8'(~k & 1));
      cmd(8'h00, 8'h60, 8'h00, 8'h00);
      // Second reset in mid-run returns everything to its reset state
      set_in(8'h00);
      @(posedge CLK_SYS);
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      model_reset();
      bus_rd(8'h04, d);
      chk(d, 32'h0);
      chk(32'(IRQ), 32'h0);
      cmd(8'h00, 8'h2f, 8'h00, 8'h00);
      tally_and_finish();
   end
endmodule : ieci_core_test
